//--- pkg/cfmg_pkg.sv
// Constants and types of the ten-channel counter, generator and capture block
package cfmg_pkg;
   localparam int NUM_CH         = 10;
   localparam int CNT_W          = 16;
   localparam int NUM_TAPS       = 5;
   localparam int CLK_PERIOD_NS  = 10;
   localparam int TAP1_PERIOD_NS = 1000;
   localparam int TICK_CYC       = (TAP1_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PRE_W          = $clog2(TICK_CYC);
   localparam int DECADE         = 10;
   localparam int ADDR_W         = 10;
   localparam int SW_W           = 2;
   // Byte address: [9:8] window, [7:4] channel, [3:2] register
   localparam int ADR_WIN_LSB    = 8;
   localparam int ADR_CH_LSB     = 4;
   localparam int ADR_RG_LSB     = 2;
   localparam logic [1:0] REG_CTRL   = 2'h0;
   localparam logic [1:0] REG_PERIOD = 2'h1;
   localparam logic [1:0] REG_HIGH   = 2'h2;
   localparam logic [1:0] REG_CAPT   = 2'h3;
   // Control word fields
   localparam int CTRL_W        = 8;
   localparam int CTRL_ARM      = 0;
   localparam int CTRL_SEQ_HI   = 1;
   localparam int CTRL_IDLE     = 2;
   localparam int CTRL_TAP_LSB  = 3;
   localparam int CTRL_MODE_LSB = 6;
   localparam int STAT_OUT      = 8;
   localparam logic [1:0] MODE_GEN    = 2'h0;
   localparam logic [1:0] MODE_PERIOD = 2'h1;
   localparam logic [1:0] MODE_HIGH   = 2'h2;
   localparam logic [7:0]  CTRL_RST = 8'h00;
   localparam logic [15:0] CNT_RST  = 16'h0000;
   typedef logic [CNT_W-1:0] cfmg_cnt_t;
   typedef logic [2:0]       cfmg_tap_t;
endpackage

//--- rtl/cfmg_top.sv
// Ten-channel square-wave generator and gate capture counter with Avalon-MM registers
// Function
// - Ten independent counter channels, one per use.
// - Timebase taps 1MHz to 100Hz by decades.
// - Generator period and duty both set per channel.
// - High-first sequence starts period high.
// - Low-first sequence starts period low.
// - Duty sets high portion; rest is low.
// - Disarmed channel holds configured idle level.
// - Arm bit runs waveform, clear disarms.
// - Pulse capture: period and high counters.
// - Results give relative frequency and duty.
// - Pulse capture pairs adjacent counters only.
// - Frequency capture uses one selected counter.
// - Registers decode at switch-set base address.
// - Each channel drives its own output pin.
`timescale 1ns/10ps
`default_nettype none
module cfmg_top (
   // Clock, reset, enable
   input  wire logic                          CLK,
   input  wire logic                          RST,
   input  wire logic                          CE,
   // Avalon-MM slave
   input  wire logic [cfmg_pkg::ADDR_W-1:0]   AVS_ADDRESS,
   input  wire logic                          AVS_READ,
   input  wire logic                          AVS_WRITE,
   input  wire logic [31:0]                   AVS_WRITEDATA,
   input  wire logic [3:0]                    AVS_BYTEENABLE,
   output      logic [31:0]                   AVS_READDATA,
   output      logic                          AVS_WAITREQUEST,
   // Base address switches and counter pins
   input  wire logic [cfmg_pkg::SW_W-1:0]     BASE_SW,
   input  wire logic [cfmg_pkg::NUM_CH-1:0]   CNT_GATE,
   output      logic [cfmg_pkg::NUM_CH-1:0]   CNT_OUT
);
   localparam int NCH = cfmg_pkg::NUM_CH;
   localparam int SYW = cfmg_pkg::NUM_CH + cfmg_pkg::SW_W;

   function automatic logic sel_tick(input logic [4:0] tk, input cfmg_pkg::cfmg_tap_t tap);
      sel_tick = (tap < 3'(cfmg_pkg::NUM_TAPS)) ? tk[tap] : 1'b0;
   endfunction

   // Level of a running generator at a given count
   function automatic logic level(input cfmg_pkg::cfmg_cnt_t cnt, input cfmg_pkg::cfmg_cnt_t per,
                                  input cfmg_pkg::cfmg_cnt_t hi, input logic seq_hi);
      if (seq_hi)
         level = (cnt < hi);
      else
         level = (hi >= per) || (cnt >= per - hi);
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
      merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   // Pin synchronisers and timebase
   logic [SYW-1:0]                  s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, f_q, f_d;
   logic [SYW-1:0]                  agree;
   logic [cfmg_pkg::PRE_W-1:0]      pre_q, pre_d;
   logic [3:0]                      dec_q [cfmg_pkg::NUM_TAPS-1];
   logic [3:0]                      dec_d [cfmg_pkg::NUM_TAPS-1];
   logic [4:0]                      tick_q, tick_d;

   always_comb begin
      s1_d   = {BASE_SW, CNT_GATE};
      s2_d   = s1_q;
      s3_d   = s2_q;
      // A pin change counts only when the last two stages agree
      agree  = ~(s2_q ^ s3_q);
      f_d    = (s3_q & agree) | (f_q & ~agree);
      dec_d  = dec_q;
      tick_d = 5'h00;
      if (pre_q == cfmg_pkg::PRE_W'(cfmg_pkg::TICK_CYC - 1)) begin
         pre_d     = '0;
         tick_d[0] = 1'b1;
      end else begin
         pre_d = pre_q + cfmg_pkg::PRE_W'(1);
      end
      for (int k = 1; k < cfmg_pkg::NUM_TAPS; k++) begin
         if (tick_d[k-1]) begin
            if (dec_q[k-1] == 4'(cfmg_pkg::DECADE - 1)) begin
               dec_d[k-1] = 4'h0;
               tick_d[k]  = 1'b1;
            end else begin
               dec_d[k-1] = dec_q[k-1] + 4'h1;
            end
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         s1_q   <= '0;
         s2_q   <= '0;
         s3_q   <= '0;
         f_q    <= '0;
         pre_q  <= '0;
         tick_q <= 5'h00;
         for (int k = 0; k < cfmg_pkg::NUM_TAPS - 1; k++) dec_q[k] <= 4'h0;
      end else if (CE) begin
         s1_q   <= s1_d;
         s2_q   <= s2_d;
         s3_q   <= s3_d;
         f_q    <= f_d;
         pre_q  <= pre_d;
         tick_q <= tick_d;
         dec_q  <= dec_d;
      end
   end

   // Bus slave and channels
   logic [7:0]             ctrl_q [NCH];
   logic [7:0]             ctrl_d [NCH];
   cfmg_pkg::cfmg_cnt_t    per_q [NCH], per_d [NCH], hi_q [NCH], hi_d [NCH];
   cfmg_pkg::cfmg_cnt_t    cnt_q [NCH], cnt_d [NCH], cap_q [NCH], cap_d [NCH];
   logic [NCH-1:0]         arm_p_q, arm_p_d, gp_q, gp_d, out_q, out_d;
   logic [31:0]            rdata_q, rdata_d;
   logic                   wait_q, wait_d;
   logic [3:0]             ch;
   logic [1:0]             rg, md;
   logic                   hit, wr, t, hmode, edge_s;
   logic [16:0]            inc;

   always_comb begin
      ch      = AVS_ADDRESS[cfmg_pkg::ADR_CH_LSB +: 4];
      rg      = AVS_ADDRESS[cfmg_pkg::ADR_RG_LSB +: 2];
      hit     = (AVS_ADDRESS[cfmg_pkg::ADR_WIN_LSB +: cfmg_pkg::SW_W] == f_q[SYW-1:NCH])
                && (ch < 4'(NCH));
      // One wait cycle, then the answer; writes land at the completing edge
      wait_d  = !((AVS_READ || AVS_WRITE) && wait_q);
      wr      = AVS_WRITE && !wait_q && hit;
      rdata_d = rdata_q;
      if (AVS_READ && wait_q) begin
         rdata_d = 32'h0000_0000;
         if (hit) begin
            case (rg)
               cfmg_pkg::REG_CTRL:   rdata_d = {23'h000000, out_q[ch], ctrl_q[ch]};
               cfmg_pkg::REG_PERIOD: rdata_d = {16'h0000, per_q[ch]};
               cfmg_pkg::REG_HIGH:   rdata_d = {16'h0000, hi_q[ch]};
               default:    rdata_d = {16'h0000, cap_q[ch]};
            endcase
         end
      end
      gp_d    = f_q[NCH-1:0];
      t       = 1'b0;
      md      = 2'h0;
      hmode   = 1'b0;
      edge_s  = 1'b0;
      inc     = 17'h00000;
      for (int c = 0; c < NCH; c++) begin
         ctrl_d[c]  = ctrl_q[c];
         per_d[c]   = per_q[c];
         hi_d[c]    = hi_q[c];
         cnt_d[c]   = cnt_q[c];
         cap_d[c]   = cap_q[c];
         arm_p_d[c] = 1'b0;
         out_d[c]   = ctrl_q[c][cfmg_pkg::CTRL_IDLE];
         if (wr && ch == 4'(c)) begin
            case (rg)
               cfmg_pkg::REG_CTRL:   ctrl_d[c] = AVS_BYTEENABLE[0] ? AVS_WRITEDATA[7:0] : ctrl_q[c];
               cfmg_pkg::REG_PERIOD: per_d[c]  = merge16(per_q[c], AVS_WRITEDATA, AVS_BYTEENABLE);
               cfmg_pkg::REG_HIGH:   hi_d[c]   = merge16(hi_q[c], AVS_WRITEDATA, AVS_BYTEENABLE);
               default:    ;
            endcase
         end
         t   = sel_tick(tick_q, ctrl_q[c][cfmg_pkg::CTRL_TAP_LSB +: 3]);
         md  = ctrl_q[c][cfmg_pkg::CTRL_MODE_LSB +: 2];
         inc = {1'b0, cnt_q[c]} + 17'h00001;
         if (md == cfmg_pkg::MODE_GEN) begin
            if (!ctrl_q[c][cfmg_pkg::CTRL_ARM]) begin
               cnt_d[c] = '0;
            end else begin
               arm_p_d[c] = 1'b1;
               if (!arm_p_q[c])
                  cnt_d[c] = '0;
               else if (t)
                  cnt_d[c] = (inc >= {1'b0, per_q[c]}) ? '0 : inc[15:0];
               out_d[c] = level(cnt_d[c], per_q[c], hi_q[c], ctrl_q[c][cfmg_pkg::CTRL_SEQ_HI]);
            end
         end else begin
            // High-time capture is the second counter of a pair, never the first
            hmode  = (md == cfmg_pkg::MODE_HIGH) && (c != 0);
            edge_s = hmode ? (!f_q[c] && gp_q[c]) : (f_q[c] && !gp_q[c]);
            if (edge_s) begin
               cap_d[c] = cnt_q[c];
               cnt_d[c] = '0;
            end else if (t && (f_q[c] || !hmode) && cnt_q[c] != '1) begin
               // Saturates so a gate slower than the count range latches as the slowest input
               cnt_d[c] = inc[15:0];
            end
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         rdata_q <= 32'h0000_0000;
         wait_q  <= 1'b1;
         arm_p_q <= '0;
         gp_q    <= '0;
         out_q   <= '0;
         for (int c = 0; c < NCH; c++) begin
            ctrl_q[c] <= cfmg_pkg::CTRL_RST;
            per_q[c]  <= cfmg_pkg::CNT_RST;
            hi_q[c]   <= cfmg_pkg::CNT_RST;
            cnt_q[c]  <= cfmg_pkg::CNT_RST;
            cap_q[c]  <= cfmg_pkg::CNT_RST;
         end
      end else if (CE) begin
         rdata_q <= rdata_d;
         wait_q  <= wait_d;
         arm_p_q <= arm_p_d;
         gp_q    <= gp_d;
         out_q   <= out_d;
         ctrl_q  <= ctrl_d;
         per_q   <= per_d;
         hi_q    <= hi_d;
         cnt_q   <= cnt_d;
         cap_q   <= cap_d;
      end
   end

   assign AVS_READDATA    = rdata_q;
   assign AVS_WAITREQUEST = wait_q;
   assign CNT_OUT         = out_q;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST || !CE);

   sequence s_req_first;
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
   endsequence

   AST_BUS_ANSWER: assert property (s_req_first |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
      else $error("bus answer not after one wait cycle");
   AST_UNMAPPED: assert property (AVS_READ && AVS_WAITREQUEST &&
                  AVS_ADDRESS[9:8] != f_q[SYW-1:NCH] |=> AVS_READDATA == 32'h0000_0000)
      else $error("read outside window not zero");
   AST_TICK_SPACING: assert property (tick_q[0] |=> !tick_q[0] [*8])
      else $error("base tick too close");
   AST_TAP_NEST: assert property (tick_q[4] |-> tick_q[3] && tick_q[2] && tick_q[1] && tick_q[0])
      else $error("slow tap not aligned to faster taps");

   for (genvar c = 0; c < NCH; c++) begin : g_ast
      logic gen_m;
      assign gen_m = ctrl_q[c][7:6] == cfmg_pkg::MODE_GEN;
      // Arm history lags the control word by one cycle, so the first armed cycle is the rise
      sequence s_arm_rise;
         gen_m && ctrl_q[c][0] && !arm_p_q[c];
      endsequence
      AST_IDLE: assert property (gen_m && !ctrl_q[c][0] ##1 $stable(ctrl_q[c]) |->
                  CNT_OUT[c] == ctrl_q[c][2])
         else $error("disarmed output not idle level");
      AST_RESTART: assert property (s_arm_rise |=> cnt_q[c] == '0)
         else $error("arming did not restart count");
      AST_HIGH_FIRST: assert property (s_arm_rise ##0 ctrl_q[c][1] && hi_q[c] != '0
                  |=> CNT_OUT[c])
         else $error("high-first period not started high");
      AST_LOW_FIRST: assert property (s_arm_rise ##0 !ctrl_q[c][1] && hi_q[c] < per_q[c]
                  |=> !CNT_OUT[c])
         else $error("low-first period not started low");
      AST_DUTY: assert property (gen_m && ctrl_q[c][0] && arm_p_q[c] && $stable(ctrl_q[c])
                  && $stable(per_q[c]) && $stable(hi_q[c]) |->
                  CNT_OUT[c] == level(cnt_q[c], per_q[c], hi_q[c], ctrl_q[c][1]))
         else $error("output level does not follow duty");
      AST_PERIOD_LATCH: assert property (ctrl_q[c][7:6] == cfmg_pkg::MODE_PERIOD && f_q[c] && !gp_q[c]
                  |=> cap_q[c] == $past(cnt_q[c]) && cnt_q[c] == '0)
         else $error("period count not latched at rising gate");
      if (c > 0) begin : g_hi
         AST_HIGH_LATCH: assert property (ctrl_q[c][7:6] == cfmg_pkg::MODE_HIGH && !f_q[c] && gp_q[c]
                     |=> cap_q[c] == $past(cnt_q[c]))
            else $error("high count not latched at falling gate");
      end
   end
endmodule
`default_nettype wire

//--- sim/cfmg_gate_src.sv
// Behavioural source of the measured signal wired to the counter gate pins
`timescale 1ns/10ps
`default_nettype none
module cfmg_gate_src (
   // Clock and reset
   input  wire logic CLK,
   input  wire logic RST,
   // Shape in clock cycles; period 0 parks the line low like a pull-down
   input  wire integer period,
   input  wire integer hi_len,
   // Signal to the gates
   output var  logic gate
);
   int cnt;
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         cnt  <= 0;
         gate <= 1'b0;
      end else begin
         cnt  <= (cnt + 1 >= period) ? 0 : cnt + 1;
         gate <= (period > 0) && (cnt < hi_len);
      end
   end
endmodule
`default_nettype wire

//--- sim/cfmg_top_tb.sv
// Self-checking bench of the counter block: generator, idle level, capture, decode
`timescale 1ns/10ps
`default_nettype none
module cfmg_top_tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [9:0]  adr = '0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdat = '0;
   logic [31:0] rdat;
   logic        wreq;
   logic [9:0]  mask = '0;
   logic [9:0]  pins;
   logic        gate;
   int          gper = 0;
   int          ghi = 0;
   int          n_fail = 0;
   int          n_compared = 0;
   always #5 clk = ~clk;
   cfmg_top dut (.CLK(clk), .RST(rst), .CE(1'b1), .AVS_ADDRESS(adr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat),
      .AVS_WAITREQUEST(wreq), .BASE_SW(2'h3), .CNT_GATE(mask & {10{gate}}), .CNT_OUT(pins));
   cfmg_gate_src src (.CLK(clk), .RST(rst), .period(gper), .hi_len(ghi), .gate(gate));
   task automatic tally_and_finish();
      if (n_fail == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input int lo, input int hi, input logic [31:0] got);
      n_compared++;
      if ($isunknown(got) || got < lo || got > hi) begin
         $display("CHECK FAILED %s expected %0d..%0d seen %0h", nm, lo, hi, got);
         n_fail++;
      end
   endtask
   function automatic logic [9:0] a(input int ch, input int rg);
      return {2'h3, ch[3:0], rg[1:0], 2'h0};
   endfunction
   // One Avalon transfer; request held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [9:0] ad, input int d, output logic [31:0] q);
      int i;
      @(posedge clk);
      adr  <= ad;
      wdat <= d;
      wr   <= w;
      rd   <= !w;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (wreq === 1'b0)
            break;
      end
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      if (i == 20) begin
         n_fail++;
         tally_and_finish();
      end
   endtask
   task automatic hicnt(input int ch, input int n, output int h);
      h = 0;
      repeat (n) begin
         @(posedge clk);
         if (pins[ch] === 1'b1)
            h++;
      end
   endtask
   initial begin
      int ch, p, h, k, tk, seq, idl, hc, e;
      logic [31:0] q;
      ch = $urandom(3);
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      // Switch synchroniser needs a few cycles before base 3 is decoded
      repeat (6) @(posedge clk);
      bus(0, a(0, 0), 0, q);
      chk("ctrl reset", 0, 0, q);
      bus(0, a(10, 0), 0, q);
      chk("unmapped channel", 0, 0, q);
      bus(1, a(1, 1) & 10'h0FF, 32'h1234, q);
      bus(0, a(1, 1), 0, q);
      chk("other window", 0, 0, q);
      for (k = 0; k < 4; k++) begin
         ch  = $urandom_range(9);
         p   = $urandom_range(5, 2);
         h   = $urandom_range(p - 1, 1);
         seq = k % 2;
         idl = (k ^ (k >> 1)) & 1;
         tk  = (k < 2) ? 100 : 1000;
         bus(1, a(ch, 1), p, q);
         bus(1, a(ch, 2), h, q);
         bus(1, a(ch, 0), (k / 2) * 8 + seq * 2 + 1, q);
         repeat (2) @(posedge clk);
         chk("first portion", seq, seq, {31'h0, pins[ch]});
         hicnt(ch, 2 * p * tk, hc);
         chk("high time", 2 * h * tk, 2 * h * tk, hc);
         bus(1, a(ch, 0), idl * 4 + (k / 2) * 8 + seq * 2, q);
         repeat (2) @(posedge clk);
         chk("idle level", idl, idl, {31'h0, pins[ch]});
         e = idl * 256 + idl * 4 + (k / 2) * 8 + seq * 2;
         bus(0, a(ch, 0), 0, q);
         chk("ctrl readback", e, e, q);
      end
      // Pair on adjacent channels, then a lone frequency counter on channel 9
      ch = $urandom_range(7);
      h  = $urandom_range(7, 2);
      mask <= (10'h3 << ch) | 10'h200;
      gper <= 1000;
      ghi  <= h * 100;
      bus(1, a(ch, 0), 32'h40, q);
      bus(1, a(ch + 1, 0), 32'h80, q);
      bus(1, a(9, 0), 32'h40, q);
      repeat (3000) @(posedge clk);
      bus(0, a(ch, 3), 0, q);
      chk("period count", 9, 10, q);
      bus(0, a(ch + 1, 3), 0, q);
      chk("high count", h - 1, h, q);
      bus(0, a(9, 3), 0, q);
      chk("single period count", 9, 10, q);
      tally_and_finish();
   end
endmodule
`default_nettype wire
